/* design/hsp_top.sv */
/*
  Two-port handshake parallel port behind an AXI4-Lite slave.
  Assumes pin inputs synchronous to mclk_i.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "hsp_defines.svh"
// Notes on behaviour
// - A two-bit global mode picks one of four port operating modes.
// - Each port has a two-bit submode refining its mode behaviour.
// - Unidirectional modes set each pin's direction from its direction bit.
// - Bidirectional ports ignore direction bits; handshake pins steer drivers.
// - Mode 0 submode 00: latched double-buffered input, strobe captures.
// - Mode 0 second pin: status input, output, interlocked or pulsed.
// - Mode 0 submode 01: double-buffered output, strobe means data taken.
// - Mode 0 submode 1X: plain pins; strobe status only, second pin status or output.
// - Port B mirrors port A submodes in mode 0.
// - Mode 1 port A is high byte or plain pins; submode ignored.
// - Mode 1 port B submode X0: latched input, strobe captures word.
// - Mode 1 port B submode X1: double-buffered output word.
// - Mode 1 port B second pin: status, output, or handshake partner.
// - Mode 2: A plain bits, B bidirectional byte, submodes unused.
// - Mode 2 A strobe acknowledges output and enables drivers.
// - Mode 2 B strobe latches input; B second pin handshakes it.
// - Mode 3 joins A high and B low into a bidirectional word.
// - Four global control bits set each handshake pin's active sense.
// - Modes 2 and 3 use the A strobe level to enable drivers.
// - Status register shows the live level of all four handshake pins.
module hsp_top #(
  parameter int PULSE_CYC = `HSP_PULSE_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic port_a_strobe_in_i,
  input wire logic port_a_handshake_second_i,
  output logic port_a_handshake_second_o,
  output logic port_a_handshake_second_oe_o,
  input wire logic port_b_strobe_in_i,
  input wire logic port_b_handshake_second_i,
  output logic port_b_handshake_second_o,
  output logic port_b_handshake_second_oe_o,
  input wire logic [7:0] first_port_pins_i,
  output logic [7:0] first_port_pins_o,
  output logic [7:0] first_port_pins_oe_o,
  input wire logic [7:0] second_port_pins_i,
  output logic [7:0] second_port_pins_o,
  output logic [7:0] second_port_pins_oe_o
);
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] sense;
    logic [1:0][7:0] pctl, ddr;
    logic [7:0] a_hold, b_hold;
    logic awrdy, awv, aerr;
    logic [2:0] aidx;
    logic wrdy, wv;
    logic [7:0] wd;
    logic wst;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy, rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pa_o, pa_oe, pb_o, pb_oe;
    logic [1:0] h2o, h2oe;
  } hsp_top_st_t;
  // Ready flags start high, all else zero.
  localparam hsp_top_st_t ST_RST = '{awrdy: 1'b1, wrdy: 1'b1,
                                     arrdy: 1'b1, default: '0};
  hsp_top_st_t q, d;
  hsp_pkg::hsp_role_t role_c [2];
  logic [2:0] h2c_c [2];
  logic [1:0][15:0] pins_c, wdat_c, rdd_c, dout_c;
  logic [1:0] wr_c, rd_c;
  logic [3:0] clr_c;
  logic [1:0] fls_c, flh_c, h2o_c, h2oe_c, stb_c, h2in_c;
  logic h1a, a_din, b_dout;
  logic [2:0] ridx;
  // Submode to channel role in mode 0.
  function automatic hsp_pkg::hsp_role_t sub_role(input logic [1:0] s);
    sub_role = s[1] ? hsp_pkg::HSP_ROLE_STAT :
               s[0] ? hsp_pkg::HSP_ROLE_DOUT : hsp_pkg::HSP_ROLE_DIN;
  endfunction : sub_role
  // Per pin: output latch or live pin.
  function automatic logic [7:0] mix(input logic [7:0] dir,
                                     input logic [7:0] hold,
                                     input logic [7:0] pin);
    mix = (dir & hold) | (~dir & pin);
  endfunction : mix
  //////////////////////////////////////////////////////////////////////
  // Mode decode per channel.
  assign role_c[0] = (q.mode == `HSP_MODE_U8) ?
                     sub_role(q.pctl[0][`HSP_SUB_HI:`HSP_SUB_LO]) :
                     (q.mode == `HSP_MODE_U16) ? hsp_pkg::HSP_ROLE_STAT :
                     hsp_pkg::HSP_ROLE_DOUT;
  assign role_c[1] = (q.mode == `HSP_MODE_U8) ?
                     sub_role(q.pctl[1][`HSP_SUB_HI:`HSP_SUB_LO]) :
                     (q.mode == `HSP_MODE_U16) ?
                     (q.pctl[1][`HSP_SUB_LO] ? hsp_pkg::HSP_ROLE_DOUT :
                      hsp_pkg::HSP_ROLE_DIN) :
                     hsp_pkg::HSP_ROLE_DIN;
  assign stb_c = {port_b_strobe_in_i, port_a_strobe_in_i};
  assign h2in_c = {port_b_handshake_second_i, port_a_handshake_second_i};
  assign pins_c[0] = (q.mode == `HSP_MODE_B16) ?
                     {first_port_pins_i, second_port_pins_i} :
                     {8'h00, first_port_pins_i};
  assign pins_c[1] = q.mode[0] ? {first_port_pins_i, second_port_pins_i} :
                     {8'h00, second_port_pins_i};
  assign h1a = (port_a_strobe_in_i == q.sense[0]);
  assign a_din = (role_c[0] == hsp_pkg::HSP_ROLE_DIN);
  assign b_dout = (role_c[1] == hsp_pkg::HSP_ROLE_DOUT);
  //////////////////////////////////////////////////////////////////////
  // Both channels; bidirectional modes force a handshake on pin two.
  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      hsp_chan_if #(.W(16)) ch ();
      assign h2c_c[gi] = q.mode[1] ?
                         {1'b1, q.pctl[gi][`HSP_H2C_PLS], 1'b0} :
                         q.pctl[gi][`HSP_H2C_HI:`HSP_H2C_LO];
      assign ch.role = role_c[gi];
      assign ch.h2_ctl = h2c_c[gi];
      assign ch.sense_s = q.sense[2 * gi];
      assign ch.sense_h = q.sense[2 * gi + 1];
      assign ch.strobe_pin = stb_c[gi];
      assign ch.h2_pin = h2in_c[gi];
      assign ch.pins = pins_c[gi];
      assign ch.wdata = wdat_c[gi];
      assign ch.wr = wr_c[gi];
      assign ch.rd = rd_c[gi];
      assign ch.clr_s = clr_c[2 * gi];
      assign ch.clr_h = clr_c[2 * gi + 1];
      assign rdd_c[gi] = ch.rd_data;
      assign dout_c[gi] = ch.dout;
      assign fls_c[gi] = ch.fl_s;
      assign flh_c[gi] = ch.fl_h;
      assign h2o_c[gi] = ch.h2_o;
      assign h2oe_c[gi] = ch.h2_oe;
      hsp_chan #(.W(16), .PULSE(PULSE_CYC)) u_chan (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ch(ch.chan)
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////
  // Bus slave, register file and pin drivers.
  always_comb begin
    d = q;
    wr_c = '0;
    rd_c = '0;
    clr_c = '0;
    wdat_c = '0;
    ridx = s_axi_araddr_i[4:2];
    // Address and data are taken in either order.
    if (s_axi_awvalid_i && q.awrdy) begin
      d.awv = 1'b1;
      d.awrdy = 1'b0;
      d.aidx = s_axi_awaddr_i[4:2];
      d.aerr = |s_axi_awaddr_i[31:5];
    end
    if (s_axi_wvalid_i && q.wrdy) begin
      d.wv = 1'b1;
      d.wrdy = 1'b0;
      d.wd = s_axi_wdata_i[7:0];
      d.wst = s_axi_wstrb_i[0];
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (q.awv && q.wv && !q.bvalid) begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
      d.bvalid = 1'b1;
      d.bresp = q.aerr ? `HSP_RESP_SLVERR : `HSP_RESP_OKAY;
      if (!q.aerr && q.wst) begin
        case (q.aidx)
          `HSP_IDX_GCTL: begin
            d.mode = q.wd[`HSP_MODE_HI:`HSP_MODE_LO];
            d.sense = q.wd[`HSP_SENSE_HI:`HSP_SENSE_LO];
          end
          `HSP_IDX_ACTL: d.pctl[0] = q.wd;
          `HSP_IDX_BCTL: d.pctl[1] = q.wd;
          `HSP_IDX_ADIR: d.ddr[0] = q.wd;
          `HSP_IDX_BDIR: d.ddr[1] = q.wd;
          `HSP_IDX_ADAT: begin
            d.a_hold = q.wd;
            wr_c[0] = (q.mode == `HSP_MODE_U8) &&
                      (role_c[0] == hsp_pkg::HSP_ROLE_DOUT);
            wdat_c[0] = {8'h00, q.wd};
          end
          `HSP_IDX_BDAT: begin
            // The low byte completes a word; the high byte waits in A.
            d.b_hold = q.wd;
            case (q.mode)
              `HSP_MODE_U8: begin
                wr_c[1] = b_dout;
                wdat_c[1] = {8'h00, q.wd};
              end
              `HSP_MODE_U16: begin
                wr_c[1] = b_dout;
                wdat_c[1] = {q.a_hold, q.wd};
              end
              `HSP_MODE_B8: begin
                wr_c[0] = 1'b1;
                wdat_c[0] = {8'h00, q.wd};
              end
              default: begin
                wr_c[0] = 1'b1;
                wdat_c[0] = {q.a_hold, q.wd};
              end
            endcase
          end
          default: clr_c = q.wd[3:0];
        endcase
      end
    end
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
      d.arrdy = 1'b1;
    end
    if (s_axi_arvalid_i && q.arrdy) begin
      d.arrdy = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = 8'h00;
      d.rresp = `HSP_RESP_OKAY;
      if (|s_axi_araddr_i[31:5]) begin
        d.rresp = `HSP_RESP_SLVERR;
      end else begin
        case (ridx)
          `HSP_IDX_GCTL: d.rdata = {q.mode, 2'h0, q.sense};
          `HSP_IDX_ACTL: d.rdata = q.pctl[0];
          `HSP_IDX_BCTL: d.rdata = q.pctl[1];
          `HSP_IDX_ADIR: d.rdata = q.ddr[0];
          `HSP_IDX_BDIR: d.rdata = q.ddr[1];
          `HSP_IDX_ADAT: begin
            // The high byte of a latched word is read without popping.
            if ((q.mode == `HSP_MODE_U8) && a_din) begin
              d.rdata = rdd_c[0][7:0];
              rd_c[0] = 1'b1;
            end else if (q.mode[0] && !b_dout) begin
              d.rdata = rdd_c[1][15:8];
            end else begin
              d.rdata = mix(q.ddr[0], q.a_hold, first_port_pins_i);
            end
          end
          `HSP_IDX_BDAT: begin
            if (role_c[1] == hsp_pkg::HSP_ROLE_DIN) begin
              d.rdata = rdd_c[1][7:0];
              rd_c[1] = 1'b1;
            end else begin
              d.rdata = mix(q.ddr[1], q.b_hold, second_port_pins_i);
            end
          end
          default: d.rdata = {port_b_handshake_second_i, port_b_strobe_in_i,
                              port_a_handshake_second_i, port_a_strobe_in_i,
                              flh_c[1], fls_c[1], flh_c[0], fls_c[0]};
        endcase
      end
    end
    // Pins: direction bits in modes 0 and 1 and for A in mode 2, A strobe level otherwise.
    case (q.mode)
      `HSP_MODE_U8: begin
        d.pa_o = (role_c[0] == hsp_pkg::HSP_ROLE_DOUT) ? dout_c[0][7:0] :
                 q.a_hold;
        d.pb_o = b_dout ? dout_c[1][7:0] : q.b_hold;
        d.pa_oe = q.ddr[0];
        d.pb_oe = q.ddr[1];
      end
      `HSP_MODE_U16: begin
        d.pa_o = b_dout ? dout_c[1][15:8] : q.a_hold;
        d.pb_o = b_dout ? dout_c[1][7:0] : q.b_hold;
        d.pa_oe = q.ddr[0];
        d.pb_oe = q.ddr[1];
      end
      `HSP_MODE_B8: begin
        d.pa_o = q.a_hold;
        d.pa_oe = q.ddr[0];
        d.pb_o = dout_c[0][7:0];
        d.pb_oe = {8{h1a}};
      end
      default: begin
        d.pa_o = dout_c[0][15:8];
        d.pb_o = dout_c[0][7:0];
        d.pa_oe = {8{h1a}};
        d.pb_oe = {8{h1a}};
      end
    endcase
    d.h2o = h2o_c;
    d.h2oe = h2oe_c;
  end
  //////////////////////////////////////////////////////////////////////
  // Top state register.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end
  // Outputs straight from the state register.
  assign s_axi_awready_o = q.awrdy;
  assign s_axi_wready_o = q.wrdy;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = q.arrdy;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = {24'h000000, q.rdata};
  assign s_axi_rresp_o = q.rresp;
  assign first_port_pins_o = q.pa_o;
  assign first_port_pins_oe_o = q.pa_oe;
  assign second_port_pins_o = q.pb_o;
  assign second_port_pins_oe_o = q.pb_oe;
  assign port_a_handshake_second_o = q.h2o[0];
  assign port_a_handshake_second_oe_o = q.h2oe[0];
  assign port_b_handshake_second_o = q.h2o[1];
  assign port_b_handshake_second_oe_o = q.h2oe[1];
endmodule : hsp_top

/* design/hsp_defines.svh */
/*
  Offsets, fields, resets and timing counts of the port.
  Assumes a 200 MHz system clock.
*/
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// Register word indices; the byte address is four times the index.
`define HSP_IDX_GCTL 3'h0
`define HSP_IDX_ACTL 3'h1
`define HSP_IDX_BCTL 3'h2
`define HSP_IDX_ADIR 3'h3
`define HSP_IDX_BDIR 3'h4
`define HSP_IDX_ADAT 3'h5
`define HSP_IDX_BDAT 3'h6
`define HSP_IDX_STAT 3'h7

// Global control: mode field and four handshake sense bits.
`define HSP_MODE_HI 7
`define HSP_MODE_LO 6
`define HSP_SENSE_HI 3
`define HSP_SENSE_LO 0

// Port control: submode field and second handshake pin control.
`define HSP_SUB_HI 7
`define HSP_SUB_LO 6
`define HSP_H2C_HI 5
`define HSP_H2C_LO 3
`define HSP_H2C_PLS 4

// Global mode encodings.
`define HSP_MODE_U8 2'h0
`define HSP_MODE_U16 2'h1
`define HSP_MODE_B8 2'h2
`define HSP_MODE_B16 2'h3

// Second handshake pin control, upper two bits of the field.
`define HSP_H2_IN 2'h0
`define HSP_H2_GPO 2'h1
`define HSP_H2_ILK 2'h2
`define HSP_H2_PLS 2'h3

// Reset value of every software register.
`define HSP_RST_REG 8'h00

// Bus responses.
`define HSP_RESP_OKAY 2'h0
`define HSP_RESP_SLVERR 2'h2

// Pulsed handshake width, rounded up to whole cycles.
`define HSP_CLK_MHZ 200
`define HSP_PULSE_NS 20
`define HSP_PULSE_CYC ((`HSP_PULSE_NS * `HSP_CLK_MHZ + 999) / 1000)

`endif

/* design/hsp_pkg.sv */
/*
  Types shared by the port modules.
  Assumes no surroundings.
*/
package hsp_pkg;

  // What one handshake channel does with its data path.
  typedef enum logic [1:0] {
    HSP_ROLE_STAT,
    HSP_ROLE_DIN,
    HSP_ROLE_DOUT
  } hsp_role_t;

endpackage : hsp_pkg

/* design/hsp_chan_if.sv */
/*
  Signals between the top level and one channel.
  Assumes the host side drives configuration and one-cycle strobes.
*/
`timescale 1ns/10ps
interface hsp_chan_if #(parameter int W = 16);
  hsp_pkg::hsp_role_t role;
  logic [2:0] h2_ctl;
  logic sense_s;
  logic sense_h;
  logic strobe_pin;
  logic h2_pin;
  logic [W-1:0] pins;
  logic [W-1:0] wdata;
  logic wr;
  logic rd;
  logic clr_s;
  logic clr_h;
  logic [W-1:0] rd_data;
  logic [W-1:0] dout;
  logic [1:0] icnt;
  logic [1:0] ocnt;
  logic h2_o;
  logic h2_oe;
  logic fl_s;
  logic fl_h;

  modport host(output role, h2_ctl, sense_s, sense_h, strobe_pin, h2_pin,
               pins, wdata, wr, rd, clr_s, clr_h,
               input rd_data, dout, icnt, ocnt, h2_o, h2_oe, fl_s, fl_h);
  modport chan(input role, h2_ctl, sense_s, sense_h, strobe_pin, h2_pin,
               pins, wdata, wr, rd, clr_s, clr_h,
               output rd_data, dout, icnt, ocnt, h2_o, h2_oe, fl_s, fl_h);
endinterface : hsp_chan_if

/* design/hsp_chan.sv */
/*
  One handshake channel with two-deep input and output buffers.
  Assumes synchronous pins and one-cycle wr/rd strobes.
*/
`timescale 1ns/10ps
`include "hsp_defines.svh"
module hsp_chan #(
  parameter int W = 16,
  parameter int PULSE = 4
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  hsp_chan_if.chan ch
);

  localparam logic [7:0] PULSE_C = 8'(PULSE);

  typedef struct packed {
    logic s_prev;
    logic h_prev;
    logic fl_s;
    logic fl_h;
    logic [1:0] icnt;
    logic [W-1:0] i0;
    logic [W-1:0] i1;
    logic [1:0] ocnt;
    logic [W-1:0] o0;
    logic [W-1:0] o1;
    logic [7:0] pcnt;
  } hsp_chan_st_t;

  hsp_chan_st_t q;
  hsp_chan_st_t d;
  logic s_act;
  logic h_act;
  logic s_edge;
  logic h_edge;
  logic h_in;
  logic h_asrt;

  //////////////////////////////////////////////////////////////////////
  // Sense, edges, buffers and second pin.
  always_comb begin
    d = q;
    s_act = (ch.strobe_pin == ch.sense_s);
    h_act = (ch.h2_pin == ch.sense_h);
    s_edge = s_act & ~q.s_prev;
    h_edge = h_act & ~q.h_prev;
    d.s_prev = s_act;
    d.h_prev = h_act;
    // A status channel senses instead of interlocking or pulsing.
    h_in = (ch.h2_ctl[2:1] == `HSP_H2_IN) ||
           (ch.role == hsp_pkg::HSP_ROLE_STAT && ch.h2_ctl[2]);
    // Set wins over a clear arriving in the same cycle.
    d.fl_s = (q.fl_s & ~ch.clr_s) | s_edge;
    d.fl_h = (q.fl_h & ~ch.clr_h) | (h_edge & h_in);
    if (q.pcnt != 8'h00) begin
      d.pcnt = q.pcnt - 8'h01;
    end
    if (ch.role != hsp_pkg::HSP_ROLE_DIN) begin
      d.icnt = 2'h0;
    end
    if (ch.role != hsp_pkg::HSP_ROLE_DOUT) begin
      d.ocnt = 2'h0;
    end
    case (ch.role)
      hsp_pkg::HSP_ROLE_DIN: begin
        // Reading frees the head before the strobe may refill it.
        if (ch.rd && q.icnt != 2'h0) begin
          d.i0 = q.i1;
          d.icnt = q.icnt - 2'h1;
        end
        if (s_edge && d.icnt != 2'h2) begin
          if (d.icnt == 2'h0) begin
            d.i0 = ch.pins;
          end else begin
            d.i1 = ch.pins;
          end
          d.icnt = d.icnt + 2'h1;
          d.pcnt = PULSE_C;
        end
      end
      hsp_pkg::HSP_ROLE_DOUT: begin
        // The strobe says the peripheral took the head word.
        if (s_edge && q.ocnt != 2'h0) begin
          if (q.ocnt == 2'h2) begin
            d.o0 = q.o1;
            d.pcnt = PULSE_C;
          end
          d.ocnt = q.ocnt - 2'h1;
        end
        // A write into a full buffer is dropped; the top never reads ocnt.
        if (ch.wr && d.ocnt != 2'h2) begin
          if (d.ocnt == 2'h0) begin
            d.o0 = ch.wdata;
            d.pcnt = PULSE_C;
          end else begin
            d.o1 = ch.wdata;
          end
          d.ocnt = d.ocnt + 2'h1;
        end
      end
      default: begin
        d.pcnt = 8'h00;
      end
    endcase
    case (ch.h2_ctl[2:1])
      `HSP_H2_GPO: h_asrt = ch.h2_ctl[0];
      `HSP_H2_ILK: h_asrt = (ch.role == hsp_pkg::HSP_ROLE_DIN) ?
                            (q.icnt != 2'h2) : (q.ocnt != 2'h0);
      `HSP_H2_PLS: h_asrt = (q.pcnt != 8'h00);
      default: h_asrt = 1'b0;
    endcase
    if (h_in) begin
      h_asrt = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Channel state register.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Results back to the top level.
  assign ch.rd_data = q.i0;
  assign ch.dout = q.o0;
  assign ch.icnt = q.icnt;
  assign ch.ocnt = q.ocnt;
  assign ch.fl_s = q.fl_s;
  assign ch.fl_h = q.fl_h;
  assign ch.h2_o = h_asrt ? ch.sense_h : ~ch.sense_h;
  assign ch.h2_oe = ~h_in;

endmodule : hsp_chan

/* tb/hsp_monitor.sv */
/*
  Bus and reset checks of the port.
  Assumes a bind into hsp_top; sees only its ports.
*/
`timescale 1ns/10ps
module hsp_monitor (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic [7:0] first_port_pins_oe_o,
  input wire logic [7:0] second_port_pins_oe_o
);
  // One clock domain.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////
  a_read_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read dropped");
  a_write_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("resp dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  a_read_upper: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h000000) else $error("upper read bits set");
  a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken during read");
  a_bad_read: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i[31:5] != 27'h0 |=> s_axi_rresp_o == 2'h2 &&
    s_axi_rdata_o == 32'h0) else $error("bad read not refused");
  a_bad_write: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o && s_axi_awaddr_i[31:5] != 27'h0
    |-> ##2 s_axi_bresp_o == 2'h2) else $error("bad write not refused");
  a_reset_inputs: assert property ($rose(nrst_i) |->
    first_port_pins_oe_o == 8'h00 && second_port_pins_oe_o == 8'h00)
    else $error("pins driven after reset");
endmodule : hsp_monitor

/* tb/hsp_periph.sv */
/*
  Peripheral model: resolves each pin from both drivers.
  Assumes the bench sets the peripheral levels on drv inputs.
*/
`timescale 1ns/10ps
module hsp_periph (
  input wire logic [7:0] a_o_i,
  input wire logic [7:0] a_oe_i,
  input wire logic [7:0] a_drv_i,
  input wire logic [7:0] b_o_i,
  input wire logic [7:0] b_oe_i,
  input wire logic [7:0] b_drv_i,
  input wire logic h2a_o_i,
  input wire logic h2a_oe_i,
  input wire logic h2b_o_i,
  input wire logic h2b_oe_i,
  output logic [7:0] a_pin_o,
  output logic [7:0] b_pin_o,
  output logic h2a_pin_o,
  output logic h2b_pin_o
);
  // The device wins on driven bits; the peripheral holds the rest.
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & a_drv_i);
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & b_drv_i);
  // Released second pins rest high on their pull-ups.
  assign h2a_pin_o = h2a_oe_i ? h2a_o_i : 1'b1;
  assign h2b_pin_o = h2b_oe_i ? h2b_o_i : 1'b1;
endmodule : hsp_periph

/* tb/hsp_tb.sv */
/*
  Self-checking bench of hsp_top with a peripheral model.
  Assumes strobes idle high, so active-low sense sees no edge at reset.
*/
`timescale 1ns/10ps
module handshake_parallel_port_modes_tb;
  logic mclk_i, nrst_i, s_axi_awvalid_i, s_axi_awready_o;
  logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i;
  logic [31:0] s_axi_rdata_o, q;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic port_a_strobe_in_i, port_a_handshake_second_i;
  logic port_a_handshake_second_o, port_a_handshake_second_oe_o;
  logic port_b_strobe_in_i, port_b_handshake_second_i;
  logic port_b_handshake_second_o, port_b_handshake_second_oe_o;
  logic [7:0] first_port_pins_i, first_port_pins_o, first_port_pins_oe_o;
  logic [7:0] second_port_pins_i, second_port_pins_o, second_port_pins_oe_o;
  logic [7:0] pa, pb, v, r;
  logic [7:0] fifo [$];
  integer seed = 32'h38a61a93;
  int err_count, n_tests, cyc;
  hsp_top hsp_top_inst (.*);
  hsp_periph hsp_periph_inst (.a_o_i(first_port_pins_o),
    .a_oe_i(first_port_pins_oe_o), .a_drv_i(pa),
    .b_o_i(second_port_pins_o), .b_oe_i(second_port_pins_oe_o),
    .b_drv_i(pb), .h2a_o_i(port_a_handshake_second_o),
    .h2a_oe_i(port_a_handshake_second_oe_o),
    .h2b_o_i(port_b_handshake_second_o),
    .h2b_oe_i(port_b_handshake_second_oe_o),
    .a_pin_o(first_port_pins_i), .b_pin_o(second_port_pins_i),
    .h2a_pin_o(port_a_handshake_second_i),
    .h2b_pin_o(port_b_handshake_second_i));
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Each channel drops when its own ready is seen.
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    while (aw || w) begin
      @(posedge mclk_i);
      if (s_axi_awready_o === 1'b1) aw = 0;
      if (s_axi_wready_o === 1'b1) w = 0;
      s_axi_awvalid_i <= aw;
      s_axi_wvalid_i <= w;
    end
    // A late ready lets the response be seen waiting.
    repeat (2) @(posedge mclk_i);
    s_axi_bready_i <= 1;
    do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'b1);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask : wr
  task rd(input logic [31:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 0;
    @(posedge mclk_i);
    s_axi_rready_i <= 1;
    do @(posedge mclk_i); while (s_axi_rvalid_o !== 1'b1);
    q = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  initial begin
    mclk_i = 0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // A hang ends the run as a failure.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  // Main sequence.
  initial begin
    {nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
    s_axi_wstrb_i = 4'hF;
    {port_a_strobe_in_i, port_b_strobe_in_i, pa, pb} = 18'h3FFFF;
    tick(16);
    nrst_i <= 1;
    tick(1);
    chk("oe_a", first_port_pins_oe_o, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(4 * i);
      chk("reset_reg", q, 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      r = $random(seed);
      v = $random(seed);
      wr(32'h0C + 4 * p, r);
      wr(32'h14 + 4 * p, v);
      tick(3);
      chk("dir", p ? second_port_pins_oe_o : first_port_pins_oe_o, r);
      chk("out", (p ? second_port_pins_o : first_port_pins_o) & r,
        v & r);
    end
    // Two strobes fill the double buffer.
    wr(32'h0C, 32'h0);
    repeat (2) begin
      v = $random(seed);
      fifo.push_back(v);
      pa <= v;
      tick(1);
      port_a_strobe_in_i <= 0;
      tick(2);
      port_a_strobe_in_i <= 1;
      tick(2);
    end
    port_b_strobe_in_i <= 0;
    tick(3);
    rd(32'h1C);
    chk("stat", q[7:4], 32'hB);
    port_b_strobe_in_i <= 1;
    repeat (2) begin
      rd(32'h14);
      chk("latch", q, fifo.pop_front());
    end
    // Second pin as general output, both senses.
    for (int s = 0; s < 2; s++) for (int p = 0; p < 2; p++) begin
      wr(32'h00, s << (1 + 2 * p));
      wr(32'h04 + 4 * p, 32'h18);
      tick(3);
      chk("h2oe", p ? port_b_handshake_second_oe_o :
        port_a_handshake_second_oe_o, 32'h1);
      chk("h2lvl", p ? port_b_handshake_second_o :
        port_a_handshake_second_o, s);
    end
    rd(32'h08);
    chk("bctl", q, 32'h18);
    // Bidirectional: A strobe level steers drivers.
    wr(32'h0C, 32'h5A);
    for (int m = 2; m < 4; m++) begin
      wr(32'h00, m << 6);
      rd(32'h00);
      chk("mode", q, m << 6);
      tick(3);
      chk("b_off", second_port_pins_oe_o, 32'h0);
      if (m == 2) chk("a_bits", first_port_pins_oe_o, 32'h5A);
      port_a_strobe_in_i <= 0;
      tick(3);
      chk("b_on", second_port_pins_oe_o, 32'hFF);
      if (m == 3) chk("a_on", first_port_pins_oe_o, 32'hFF);
      port_a_strobe_in_i <= 1;
      tick(3);
    end
    wr(32'h40, 32'h1);
    chk("bresp", rsp, 32'h2);
    rd(32'h40);
    chk("rresp", rsp, 32'h2);
    chk("rdata_bad", q, 32'h0);
    complete_run;
  end
endmodule : handshake_parallel_port_modes_tb
bind hsp_top hsp_monitor hsp_monitor_inst (.*);
